// ### logic/spsp_pkg.sv
package spsp_pkg;
   // control register fields
   localparam int CTL_DONE_BIT  = 7;
   localparam int CTL_WRITE_COLLISION_FLAG_BIT  = 6;
   localparam int CTL_MODE_FAULT_FLAG_BIT  = 5;
   localparam int CTL_OVR_BIT   = 4;
   localparam int CTL_SMHI_BIT  = 3;
   localparam int CTL_SMLO_BIT  = 2;
   localparam int CTL_TXMT_BIT  = 1;
   localparam int CTL_EN_BIT    = 0;
   localparam logic [7:0] CTL_RESET = 8'h06;
   // config register fields
   localparam int CFG_MASTER_ENABLE_BIT = 6;
   localparam int CFG_PHA_BIT   = 5;
   localparam int CFG_POL_BIT   = 4;
   localparam int CFG_IEN_BIT   = 0;
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h00;
   // select modes
   localparam logic [1:0] SM_THREE_WIRE = 2'h0;
   localparam logic [1:0] SM_FOUR_WIRE  = 2'h1;
   // bits per byte and last bit index
   localparam int          BYTE_BITS = 8;
   localparam logic [2:0]  LAST_BIT  = 3'h7;
   localparam logic [2:0]  FIRST_BIT = 3'h0;
   // timing
   localparam int SYS_PERIOD_NS = 8;
   localparam int SS_SETUP_NS   = 16;
   localparam int SS_SETUP_CYC  = (SS_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int SCK_HALF_DEF  = 6;
   localparam int SCK_HALF_MIN  = 5;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
endpackage : spsp_pkg

// ### logic/spsp_link_if.sv
`timescale 1ns/100ps
interface spsp_link_if;
   logic sck;
   logic slave_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport dev (input sck, input slave_select_n, input mosi, output miso, output miso_oe);
   modport ctl (output sck, output slave_select_n, output mosi, input miso, input miso_oe);
endinterface : spsp_link_if

// ### logic/spsp_sync.sv
`timescale 1ns/100ps
module spsp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_r;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_r <= RESET_VAL;
         q_out  <= RESET_VAL;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule : spsp_sync

// ### logic/spsp_master.sv
`timescale 1ns/100ps
module spsp_master #(
   parameter int SCK_HALF = spsp_pkg::SCK_HALF_DEF
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   spsp_link_if.ctl        link,
   input  wire logic       clock_phase_sel_in,
   input  wire logic       clock_polarity_sel_in,
   input  wire logic       start_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            busy_out,
   output logic            done_out,
   output logic [7:0]      rx_byte_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_HOLD} spsp_mst_t;

   // elaboration check: half period bounds the bit rate
   if (SCK_HALF < spsp_pkg::SCK_HALF_MIN) begin : g_half_chk
      $error("SCK_HALF too small for slave rate");
   end

   spsp_mst_t  state_r;
   logic [7:0] div_r;
   logic [4:0] edge_r;
   logic [7:0] sh_r;
   logic       miso_s;
   logic       tick;
   logic       leading;
   logic       sample_now;

   spsp_sync u_miso (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(link.miso), .q_out(miso_s));

   assign tick       = (div_r == 8'(SCK_HALF - 1));
   assign leading    = ~edge_r[0];
   assign sample_now = (leading ^ clock_phase_sel_in);

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r             <= ST_IDLE;
         div_r               <= 8'h00;
         edge_r              <= 5'h00;
         sh_r                <= 8'h00;
         busy_out            <= 1'b0;
         done_out            <= 1'b0;
         rx_byte_out         <= 8'h00;
         link.sck            <= 1'b0;
         link.slave_select_n <= 1'b1;
         link.mosi           <= 1'b0;
      end else begin
         done_out <= 1'b0;
         div_r    <= tick ? 8'h00 : div_r + 8'h01;
         case (state_r)
            ST_IDLE: begin
               link.sck <= clock_polarity_sel_in;
               if (start_in) begin
                  state_r             <= ST_SETUP;
                  busy_out            <= 1'b1;
                  sh_r                <= tx_byte_in;
                  link.mosi           <= tx_byte_in[7];
                  link.slave_select_n <= 1'b0;
                  div_r               <= 8'h00;
                  edge_r              <= 5'h00;
               end
            end
            ST_SETUP: begin
               if (div_r >= 8'(spsp_pkg::SS_SETUP_CYC) && tick) state_r <= ST_RUN;
            end
            ST_RUN: begin
               if (tick) begin
                  link.sck <= clock_polarity_sel_in ^ leading;
                  edge_r   <= edge_r + 5'h01;
                  if (sample_now) begin
                     sh_r <= {sh_r[6:0], miso_s};
                  end else if (edge_r != 5'h00) begin
                     link.mosi <= sh_r[7];
                  end
                  if (edge_r == spsp_pkg::EDGES_PER_BYTE - 5'h01) state_r <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (tick) begin
                  state_r             <= ST_IDLE;
                  link.slave_select_n <= 1'b1;
                  busy_out            <= 1'b0;
                  done_out            <= 1'b1;
                  rx_byte_out         <= sh_r;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule : spsp_master

// ### logic/spsp_device.sv
`timescale 1ns/100ps
module spsp_device (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   spsp_link_if.dev        link,
   input  wire logic       ctl_wr_in,
   input  wire logic [7:0] ctl_data_in,
   input  wire logic       cfg_wr_in,
   input  wire logic [7:0] cfg_data_in,
   input  wire logic       rate_wr_in,
   input  wire logic [7:0] rate_data_in,
   input  wire logic       data_wr_in,
   input  wire logic [7:0] data_wr_data_in,
   input  wire logic       data_rd_in,
   output logic [7:0]      data_out,
   output logic [7:0]      port_control_out,
   output logic [7:0]      port_config_out,
   output logic [7:0]      clock_rate_out,
   output logic            port_irq_out
);
   // system domain state
   logic       done_flag_r, write_collision_flag_flag_r, mode_fault_flag_flag_r, ovr_flag_r;
   logic [1:0] sel_mode_r;
   logic       en_r, master_enable_r, pha_r, pol_r, ien_r;
   logic [7:0] rate_r;
   logic [7:0] tx_hold_r;
   logic       tx_pend_r;
   logic       rx_full_r;
   logic [7:0] rx_buf_r;
   logic       done_seen_r, take_seen_r, ss_seen_r;
   // link domain state
   logic [2:0] scnt_r, dcnt_r;
   logic [7:0] rsh_r, txsh_r, rx_byte_r;
   logic       done_tgl_r, take_tgl_r;
   // crossings
   logic       done_s, take_s, ss_s, pend_s;
   logic       samp_clk, drv_clk, link_rst, four_wire, slave_on;
   logic       done_ev, take_ev, ss_fall, set_write_collision_flag, set_mode_fault_flag, set_ovr;

   function automatic logic flag_next(input logic cur, input logic set, input logic wr,
                                      input logic wbit);
      flag_next = set | (cur & ~(wr & ~wbit));
   endfunction : flag_next

   assign four_wire = (sel_mode_r == spsp_pkg::SM_FOUR_WIRE);
   assign slave_on  = en_r & ~master_enable_r;
   // sample edge chosen by phase and polarity
   assign samp_clk  = link.sck ^ pol_r ^ pha_r;
   assign drv_clk   = ~samp_clk;
   // counters held in reset while disabled or while deselected in four-wire mode
   assign link_rst  = rst_in | ~slave_on | (four_wire & link.slave_select_n);

   spsp_sync u_done (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(done_tgl_r), .q_out(done_s));
   spsp_sync u_take (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(take_tgl_r), .q_out(take_s));
   spsp_sync #(.RESET_VAL(1'b1)) u_ss (
      .clk_in(ref_clk_in), .rst_in(rst_in), .d_in(link.slave_select_n), .q_out(ss_s));
   // link clock stops between bytes, so a two-stage sync on it would lag the load edge;
   // the pending flag is quasi-static: set before the byte, cleared only after the take
   assign pend_s = tx_pend_r;

   // edge detection in system domain
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         done_seen_r <= 1'b0;
         take_seen_r <= 1'b0;
         ss_seen_r   <= 1'b1;
      end else begin
         done_seen_r <= done_s;
         take_seen_r <= take_s;
         ss_seen_r   <= ss_s;
      end
   end

   assign done_ev  = done_s ^ done_seen_r;
   assign take_ev  = take_s ^ take_seen_r;
   assign ss_fall  = ss_seen_r & ~ss_s;
   assign set_write_collision_flag = data_wr_in & tx_pend_r;
   assign set_mode_fault_flag = master_enable_r & en_r & four_wire & ss_fall;
   assign set_ovr  = done_ev & rx_full_r;

   // status flags, set wins over software clear
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         done_flag_r <= spsp_pkg::CTL_RESET[spsp_pkg::CTL_DONE_BIT];
         write_collision_flag_flag_r <= spsp_pkg::CTL_RESET[spsp_pkg::CTL_WRITE_COLLISION_FLAG_BIT];
         mode_fault_flag_flag_r <= spsp_pkg::CTL_RESET[spsp_pkg::CTL_MODE_FAULT_FLAG_BIT];
         ovr_flag_r  <= spsp_pkg::CTL_RESET[spsp_pkg::CTL_OVR_BIT];
      end else begin
         done_flag_r <= flag_next(done_flag_r, done_ev, ctl_wr_in,
                                  ctl_data_in[spsp_pkg::CTL_DONE_BIT]);
         write_collision_flag_flag_r <= flag_next(write_collision_flag_flag_r, set_write_collision_flag, ctl_wr_in,
                                  ctl_data_in[spsp_pkg::CTL_WRITE_COLLISION_FLAG_BIT]);
         mode_fault_flag_flag_r <= flag_next(mode_fault_flag_flag_r, set_mode_fault_flag, ctl_wr_in,
                                  ctl_data_in[spsp_pkg::CTL_MODE_FAULT_FLAG_BIT]);
         ovr_flag_r  <= flag_next(ovr_flag_r, set_ovr, ctl_wr_in,
                                  ctl_data_in[spsp_pkg::CTL_OVR_BIT]);
      end
   end

   // control and configuration settings
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sel_mode_r <= {spsp_pkg::CTL_RESET[spsp_pkg::CTL_SMHI_BIT],
                        spsp_pkg::CTL_RESET[spsp_pkg::CTL_SMLO_BIT]};
         en_r       <= spsp_pkg::CTL_RESET[spsp_pkg::CTL_EN_BIT];
         master_enable_r    <= spsp_pkg::CFG_RESET[spsp_pkg::CFG_MASTER_ENABLE_BIT];
         pha_r      <= spsp_pkg::CFG_RESET[spsp_pkg::CFG_PHA_BIT];
         pol_r      <= spsp_pkg::CFG_RESET[spsp_pkg::CFG_POL_BIT];
         ien_r      <= spsp_pkg::CFG_RESET[spsp_pkg::CFG_IEN_BIT];
         rate_r     <= spsp_pkg::RATE_RESET;
      end else begin
         if (ctl_wr_in) begin
            sel_mode_r <= {ctl_data_in[spsp_pkg::CTL_SMHI_BIT], ctl_data_in[spsp_pkg::CTL_SMLO_BIT]};
            en_r       <= ctl_data_in[spsp_pkg::CTL_EN_BIT];
         end
         if (cfg_wr_in) begin
            master_enable_r <= cfg_data_in[spsp_pkg::CFG_MASTER_ENABLE_BIT];
            pha_r   <= cfg_data_in[spsp_pkg::CFG_PHA_BIT];
            pol_r   <= cfg_data_in[spsp_pkg::CFG_POL_BIT];
            ien_r   <= cfg_data_in[spsp_pkg::CFG_IEN_BIT];
         end
         if (set_mode_fault_flag) begin
            en_r    <= 1'b0;
            master_enable_r <= 1'b0;
         end
         // stored for reads only, no effect on slave timing
         if (rate_wr_in) rate_r <= rate_data_in;
      end
   end

   // transmit buffer: pending until the link takes it
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_hold_r <= 8'h00;
         tx_pend_r <= 1'b0;
      end else begin
         if (data_wr_in && !tx_pend_r) begin
            tx_hold_r <= data_wr_data_in;
            tx_pend_r <= 1'b1;
         end else if (take_ev) begin
            tx_pend_r <= 1'b0;
         end
      end
   end

   // receive buffer with overrun protection
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_buf_r  <= 8'h00;
         rx_full_r <= 1'b0;
      end else begin
         if (done_ev && !rx_full_r) begin
            rx_buf_r  <= rx_byte_r;
            rx_full_r <= 1'b1;
         end else if (data_rd_in) begin
            rx_full_r <= 1'b0;
         end
      end
   end

   // register views and interrupt
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_out         <= 8'h00;
         port_control_out <= spsp_pkg::CTL_RESET;
         port_config_out  <= spsp_pkg::CFG_RESET;
         clock_rate_out   <= spsp_pkg::RATE_RESET;
         port_irq_out     <= 1'b0;
         link.miso_oe     <= 1'b0;
      end else begin
         data_out         <= rx_buf_r;
         port_control_out <= {done_flag_r, write_collision_flag_flag_r, mode_fault_flag_flag_r, ovr_flag_r,
                              sel_mode_r, ~tx_pend_r, en_r};
         port_config_out  <= {1'b0, master_enable_r, pha_r, pol_r, 3'h0, ien_r};
         clock_rate_out   <= rate_r;
         port_irq_out     <= ien_r & (done_flag_r | write_collision_flag_flag_r | mode_fault_flag_flag_r | ovr_flag_r);
         // slave only answers, never drives the clock
         link.miso_oe     <= slave_on & (~four_wire | ~ss_s);
      end
   end

   // link domain: sample edge
   always_ff @(posedge samp_clk or posedge link_rst) begin
      if (link_rst) begin
         scnt_r <= spsp_pkg::FIRST_BIT;
         rsh_r  <= 8'h00;
      end else begin
         scnt_r <= scnt_r + 3'h1;
         rsh_r  <= {rsh_r[6:0], link.mosi};
      end
   end

   always_ff @(posedge samp_clk or posedge rst_in) begin
      if (rst_in) begin
         rx_byte_r  <= 8'h00;
         done_tgl_r <= 1'b0;
      end else if (!link_rst && scnt_r == spsp_pkg::LAST_BIT) begin
         rx_byte_r  <= {rsh_r[6:0], link.mosi};
         done_tgl_r <= ~done_tgl_r;
      end
   end

   // link domain: drive edge
   always_ff @(posedge drv_clk or posedge link_rst) begin
      if (link_rst) begin
         dcnt_r <= spsp_pkg::FIRST_BIT;
      end else begin
         dcnt_r <= dcnt_r + 3'h1;
      end
   end

   always_ff @(posedge drv_clk or posedge rst_in) begin
      if (rst_in) begin
         txsh_r     <= 8'h00;
         take_tgl_r <= 1'b0;
      end else if (!link_rst) begin
         if ((pha_r ? dcnt_r == spsp_pkg::FIRST_BIT : dcnt_r == spsp_pkg::LAST_BIT)) begin
            if (pend_s) begin
               txsh_r     <= tx_hold_r;
               take_tgl_r <= ~take_tgl_r;
            end
         end else begin
            txsh_r <= {txsh_r[6:0], 1'b0};
         end
      end
   end

   assign link.miso = txsh_r[7];
endmodule : spsp_device

// ### dv/spsp_chk.sv
`timescale 1ns/100ps
module spsp_chk (
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic       sck,
   input wire logic       slave_select_n,
   input wire logic       miso_oe,
   input wire logic       ctl_wr_in,
   input wire logic [7:0] ctl_data_in,
   input wire logic       data_wr_in,
   input wire logic [7:0] port_control_out,
   input wire logic [7:0] port_config_out,
   input wire logic [7:0] data_out,
   input wire logic       port_irq_out,
   input wire logic       done_out
);
   logic [15:0] clr_q;
   logic        four_wire;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   assign four_wire = (port_control_out[3:2] == spsp_pkg::SM_FOUR_WIRE);
   // software clear masks of the last four cycles
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clr_q <= 16'h0000;
      end else begin
         clr_q <= {clr_q[11:0], ctl_wr_in ? ~ctl_data_in[7:4] : 4'h0};
      end
   end
   sequence s_sck_quiet; $stable(sck) [*2]; endsequence
   sequence s_fault; port_control_out[5] && !port_control_out[0] && !port_config_out[6];
   endsequence
   property p_ss_setup; $fell(slave_select_n) |-> s_sck_quiet; endproperty
   property p_sck_rate; $changed(sck) |=> $stable(sck) [*4]; endproperty
   property p_oe_off; (four_wire && slave_select_n) [*5] |-> !miso_oe; endproperty
   property p_oe_on;
      (four_wire && port_control_out[0] && !port_config_out[6] && !slave_select_n) [*5]
         |-> miso_oe;
   endproperty
   property p_done;
      done_out && port_control_out[0] && !port_config_out[6] && !port_control_out[3]
         |-> ##[0:8] port_control_out[7];
   endproperty
   property p_flag_hold;
      (($past(port_control_out[7:4]) & ~port_control_out[7:4])
         & ~(clr_q[15:12] | clr_q[11:8] | clr_q[7:4] | clr_q[3:0])) == 4'h0;
   endproperty
   property p_irq;
      $stable({port_config_out[0], |port_control_out[7:4]})
         |-> port_irq_out == (port_config_out[0] && |port_control_out[7:4]);
   endproperty
   property p_write_collision_flag; data_wr_in && !port_control_out[1] |-> ##[1:4] port_control_out[6];
   endproperty
   property p_ovr; $rose(port_control_out[4]) |-> data_out == $past(data_out, 8); endproperty
   property p_mode_fault_flag;
      port_config_out[6] && port_control_out[0] && four_wire && $fell(slave_select_n)
         |-> ##[1:10] s_fault;
   endproperty
   a_ss_setup: assert property (p_ss_setup) else $error("clock edge too soon");
   a_sck_rate: assert property (p_sck_rate) else $error("clock too fast");
   a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
   a_oe_on: assert property (p_oe_on) else $error("not driving when selected");
   a_done: assert property (p_done) else $error("byte end flag missing");
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
   a_irq: assert property (p_irq) else $error("irq mismatch");
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag missing");
   a_ovr: assert property (p_ovr) else $error("buffer overwritten");
   a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault missing");
endmodule : spsp_chk

// ### dv/test_spi_slave_port.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %0h got %0h", nm, (e), (g)); end end
module test_spi_slave_port;
   logic       ref_clk;
   logic       rst;
   logic       ctl_wr, cfg_wr, rate_wr, data_wr, data_rd, start, mpha, mpol, irq, mdone;
   logic [7:0] wdat, mtx, mrx, dev_data, ctl_view, cfg_view, rate_view;
   int         fail_count, num_checks, cyc;
   spsp_link_if spsp_link_if_inst ();
   spsp_master spsp_master_inst (.ref_clk_in(ref_clk), .rst_in(rst), .link(spsp_link_if_inst),
      .clock_phase_sel_in(mpha), .clock_polarity_sel_in(mpol), .start_in(start),
      .tx_byte_in(mtx), .busy_out(), .done_out(mdone), .rx_byte_out(mrx));
   spsp_device spsp_device_inst (.ref_clk_in(ref_clk), .rst_in(rst), .link(spsp_link_if_inst),
      .ctl_wr_in(ctl_wr), .ctl_data_in(wdat), .cfg_wr_in(cfg_wr), .cfg_data_in(wdat),
      .rate_wr_in(rate_wr), .rate_data_in(wdat), .data_wr_in(data_wr),
      .data_wr_data_in(wdat), .data_rd_in(data_rd), .data_out(dev_data),
      .port_control_out(ctl_view), .port_config_out(cfg_view), .clock_rate_out(rate_view),
      .port_irq_out(irq));
   spsp_chk spsp_chk_inst (.ref_clk_in(ref_clk), .rst_in(rst), .sck(spsp_link_if_inst.sck),
      .slave_select_n(spsp_link_if_inst.slave_select_n), .miso_oe(spsp_link_if_inst.miso_oe),
      .ctl_wr_in(ctl_wr), .ctl_data_in(wdat), .data_wr_in(data_wr),
      .port_control_out(ctl_view), .port_config_out(cfg_view), .data_out(dev_data),
      .port_irq_out(irq), .done_out(mdone));
   always #4 ref_clk = ~ref_clk;
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   // sel: 0 control, 1 config, 2 rate, 3 data write, 4 data read
   task automatic wr(input logic [2:0] sel, input logic [7:0] v);
      @(posedge ref_clk);
      #1;
      {ctl_wr, cfg_wr, rate_wr} = {sel == 3'h0, sel == 3'h1, sel == 3'h2};
      {data_wr, data_rd} = {sel == 3'h3, sel == 3'h4};
      wdat = v;
      @(posedge ref_clk);
      #1;
      {ctl_wr, cfg_wr, rate_wr, data_wr, data_rd} = 5'h00;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : wr
   task automatic xfer(input logic [7:0] v);
      int n;
      @(posedge ref_clk);
      #1;
      start = 1'b1;
      mtx = v;
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      n = 0;
      while (mdone !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 400) fail_count++;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : xfer
   initial begin
      int m;
      logic [7:0] t;
      {ref_clk, rst, ctl_wr, cfg_wr, rate_wr, data_wr, data_rd, start} = 8'h40;
      {wdat, mtx, mpha, mpol} = 18'h00000;
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      `CHK("control", spsp_pkg::CTL_RESET, ctl_view)
      `CHK("config", spsp_pkg::CFG_RESET, cfg_view)
      wr(3'h2, 8'h3b);
      `CHK("rate", 8'h3b, rate_view)
      for (m = 0; m < 4; m++) begin
         wr(3'h0, 8'hf4);
         {mpha, mpol} = m[1:0];
         wr(3'h1, {2'h0, m[1:0], 4'h1});
         `CHK("config", {2'h0, m[1:0], 4'h1}, cfg_view)
         wr(3'h0, 8'hf5);
         t = 8'h5a ^ m[7:0];
         wr(3'h3, t);
         xfer(8'hc3 ^ m[7:0]);
         if (m[1]) `CHK("master rx", t, mrx)
         `CHK("rx buffer", 8'hc3 ^ m[7:0], dev_data)
         `CHK("done flag", 1'b1, ctl_view[7])
         `CHK("irq", 1'b1, irq)
         if (!m[1]) begin
            xfer(8'h0f);
            `CHK("master rx", t, mrx)
            `CHK("overrun", 1'b1, ctl_view[4])
            `CHK("rx kept", 8'hc3 ^ m[7:0], dev_data)
         end
         wr(3'h4, 8'h00);
         wr(3'h0, 8'h05);
         `CHK("flags", 4'h0, ctl_view[7:4])
         `CHK("irq", 1'b0, irq)
      end
      wr(3'h3, 8'h96);
      wr(3'h3, 8'h69);
      `CHK("collision", 1'b1, ctl_view[6])
      xfer(8'h11);
      `CHK("master rx", 8'h96, mrx)
      `CHK("miso enable", 1'b0, spsp_link_if_inst.miso_oe)
      wr(3'h4, 8'h00);
      wr(3'h0, 8'hf0);
      wr(3'h0, 8'hf1);
      `CHK("miso enable", 1'b1, spsp_link_if_inst.miso_oe)
      xfer(8'h77);
      `CHK("rx buffer", 8'h77, dev_data)
      wr(3'h4, 8'h00);
      wr(3'h1, 8'h40);
      wr(3'h0, 8'hf5);
      xfer(8'h00);
      `CHK("mode fault", 3'h4, {ctl_view[5], ctl_view[0], cfg_view[6]})
      print_verdict();
   end
endmodule : test_spi_slave_port
